// >>> hw/pmu_activity_timers_defs.svh
// Offsets, field positions, reset values and timing counts of the activity timer block.
`ifndef PMU_ACTIVITY_TIMERS_DEFS_SVH
`define PMU_ACTIVITY_TIMERS_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_INPUT_TIMER 8'h3a
`define IDX_MEMORY_TIMER 8'h3b
`define IDX_LED_MONITOR 8'h3c
`define IDX_MISC_ONE 8'h3d
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_MASK 8'h31
`define BYTE_ADDR(idx) ({idx, 2'h0})

// Reset values.
`define RST_TIMER 8'h00
`define RST_LED_MONITOR 8'h03
`define RST_MISC_ONE 8'h01
`define RST_IRQ 3'h0

// Miscellaneous register field positions.
`define MISC_FULL_DECODE 0
`define MISC_GLOBAL_LIVE 1
`define MISC_RESUME 2

// Interrupt status bit positions.
`define IRQ_INPUT_TIMEOUT 0
`define IRQ_MEMORY_TIMEOUT 1
`define IRQ_RESUME 2

// Timing: the clock period and the half second that all slow counts step on.
`define CLK_PERIOD_PS 64'd5000
`define HALF_SEC_MS 64'd500
`define HALF_SEC_CYCLES ((`HALF_SEC_MS * 64'd1000000000) / `CLK_PERIOD_PS)

// Time bases and LED half periods counted in half seconds.
`define HALVES_1S 12'd2
`define HALVES_10S 12'd20
`define HALVES_1MIN 12'd120
`define HALVES_10MIN 12'd1200
`define LED_HALVES_1S 5'd1
`define LED_HALVES_4S 5'd4
`define LED_HALVES_8S 5'd8
`define LED_HALVES_16S 5'd16

// A zero timeout count stands for sixteen units.
`define TIMEOUT_ZERO_UNITS 5'd16

// Monitored address windows.
`define DISP_MEM_TOP 7'h05
`define DISP_IO_FULL 12'h03b
`define DISP_IO_SHORT 6'h3b

`endif

// >>> hw/pmu_activity_timers_pkg.sv
// Types shared by the activity timer block.
package pmu_activity_timers_pkg;

  // One timer setting register.
  typedef struct packed {
    logic [3:0] timer_count_nibble;
    logic read_live;
    logic run;
    logic [1:0] time_base_field;
  } timer_cfg_s;

  // The LED flash and monitor range register.
  typedef struct packed {
    logic [1:0] led_period_field;
    logic led_flash_en;
    logic gpio_3xx_en;
    logic gpio_2xx_en;
    logic gpio_1xx_en;
    logic disp_io_en;
    logic disp_mem_en;
  } led_cfg_s;

  // Time base codes.
  typedef enum logic [1:0] {
    BASE_1S,
    BASE_10S,
    BASE_1MIN,
    BASE_10MIN
  } time_base_e;

endpackage

// >>> hw/pmu_activity_timers.sv
// Power-management inactivity timers, activity monitors and mode LED flasher.
//
// Functional notes
// RULE1 - Timer bits 1:0 pick a time base of 1s, 10s, 1min or 10min.
// RULE2 - Timer bit 2 low holds the count clear; high lets it count up.
// RULE3 - Timer bit 3 high reads the live count in bits 7:4, else the setting.
// RULE4 - Bits 7:4 hold a timeout count from 0 to 15.
// RULE5 - A second timer for the memory region has the same fields.
// RULE6 - Bit 0 counts display memory writes at A0000h-BFFFFh as display activity.
// RULE7 - Bit 1 counts I/O writes to 3B0h-3BFh as display activity.
// RULE8 - Bits 2, 3, 4 add I/O ranges 1xxh, 2xxh, 3xxh to general I/O.
// RULE9 - Bit 5 flashes the mode LED at a 50% duty cycle.
// RULE10 - Bits 7:6 pick LED flash period of 1, 4, 8 or 16 seconds.
// RULE11 - Misc bit 0 enables full I/O address decoding, reset to one.
// RULE12 - Misc bit 1 enables global live count readback, reset to zero.
// RULE13 - Misc bit 2 is the resume indicator for the SMI routine.
// RULE14 - Timeout equals count times base, zero means sixteen; doubling doubles it.
// RULE15 - Full decoding compares address lines 15:0, otherwise lines 9:0.
// RULE16 - Global live feature makes every timer read its live count.
// RULE17 - SMI software writes one to the resume bit just before resuming.
// RULE18 - Reaching the timeout raises an event; group activity clears the count.
// RULE19 - Misc bits 7:3 read as zero.
`timescale 1ns/1ps
`include "pmu_activity_timers_defs.svh"

module pmu_activity_timers
  import pmu_activity_timers_pkg::*;
#(
  parameter int unsigned HALF_SEC_CYCLES = 32'(`HALF_SEC_CYCLES),
  parameter int unsigned NUM_TIMERS = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored ISA bus pins.
  input wire logic [23:0] isa_addr,
  input wire logic isa_iow_n,
  input wire logic isa_memw_n,
  input wire logic input_device_activity,
  input wire logic general_memory_region_group_hit,
  // Power management unit side, same clock.
  input wire logic double_time_base,
  input wire logic mode_led_steady,
  // Events and indicators.
  output logic input_timeout,
  output logic memory_timeout,
  output logic display_activity,
  output logic general_io_port_group_activity,
  output logic resume_indicator,
  output logic mode_led,
  output logic irq
);

  // Refuse parameter values that the logic cannot serve.
  if (HALF_SEC_CYCLES < 2 || NUM_TIMERS != 2) begin : g_bad_params
    $error("pmu_activity_timers: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  timer_cfg_s timer_cfg_q [NUM_TIMERS];
  led_cfg_s led_cfg_q;
  logic [2:0] misc_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Address match for each register and the completing edge of a transfer.
  wire logic hit_input = paddr == 12'(`BYTE_ADDR(`IDX_INPUT_TIMER));
  wire logic hit_memory = paddr == 12'(`BYTE_ADDR(`IDX_MEMORY_TIMER));
  wire logic hit_led = paddr == 12'(`BYTE_ADDR(`IDX_LED_MONITOR));
  wire logic hit_misc = paddr == 12'(`BYTE_ADDR(`IDX_MISC_ONE));
  wire logic hit_status = paddr == 12'(`BYTE_ADDR(`IDX_IRQ_STATUS));
  wire logic hit_mask = paddr == 12'(`BYTE_ADDR(`IDX_IRQ_MASK));
  wire logic hit_any = hit_input | hit_memory | hit_led | hit_misc | hit_status | hit_mask;
  wire logic access = psel & penable & ~pready_q;
  wire logic done = psel & penable & pready_q;
  wire logic wr_done = done & pwrite & hit_any;
  wire logic [7:0] wbyte = pwdata[7:0];

  // Writing one to the resume bit is itself an event.
  wire logic resume_write = wr_done & hit_misc & wbyte[`MISC_RESUME]; // RULE17

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three flops, a change counts once the last two agree.

  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_stable_q;
  logic [23:0] addr_s1_q;
  logic [23:0] addr_s2_q;
  wire logic [3:0] pin_raw = {general_memory_region_group_hit, input_device_activity,
                              ~isa_memw_n, ~isa_iow_n};
  wire logic [3:0] pin_rise;

  // Each pin settles only when the second and third stages agree.
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1_q[gp] <= 1'b0;
          pin_s2_q[gp] <= 1'b0;
          pin_s3_q[gp] <= 1'b0;
          pin_stable_q[gp] <= 1'b0;
        end else begin
          pin_s1_q[gp] <= pin_raw[gp];
          pin_s2_q[gp] <= pin_s1_q[gp];
          pin_s3_q[gp] <= pin_s2_q[gp];
          if (pin_s2_q[gp] == pin_s3_q[gp]) begin
            pin_stable_q[gp] <= pin_s3_q[gp];
          end
        end
      end
      assign pin_rise[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) & pin_s3_q[gp] & ~pin_stable_q[gp];
    end
  endgenerate

  // The address is held by the bus for the whole strobe, so two stages suffice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_s1_q <= 24'h000000;
      addr_s2_q <= 24'h000000;
    end else begin
      addr_s1_q <= isa_addr;
      addr_s2_q <= addr_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity decode.

  // Full decoding looks at lines 15:0; short decoding ignores lines above 9.
  wire logic full_dec = misc_q[`MISC_FULL_DECODE]; // RULE11
  wire logic upper_ok = full_dec ? (addr_s2_q[15:10] == 6'h00) : 1'b1; // RULE15
  wire logic io_wr = pin_rise[0];
  wire logic mem_wr = pin_rise[1];
  wire logic disp_mem_hit = addr_s2_q[23:17] == `DISP_MEM_TOP; // RULE6
  wire logic disp_io_hit = full_dec ? (addr_s2_q[15:4] == `DISP_IO_FULL)
                                    : (addr_s2_q[9:4] == `DISP_IO_SHORT); // RULE15
  wire logic gpio_1xx = upper_ok & (addr_s2_q[9:8] == 2'h1);
  wire logic gpio_2xx = upper_ok & (addr_s2_q[9:8] == 2'h2);
  wire logic gpio_3xx = upper_ok & (addr_s2_q[9:8] == 2'h3);
  wire logic disp_event = (mem_wr & disp_mem_hit & led_cfg_q.disp_mem_en) // RULE6
                        | (io_wr & disp_io_hit & led_cfg_q.disp_io_en); // RULE7
  wire logic gpio_event = io_wr & ((gpio_1xx & led_cfg_q.gpio_1xx_en)
                                 | (gpio_2xx & led_cfg_q.gpio_2xx_en)
                                 | (gpio_3xx & led_cfg_q.gpio_3xx_en)); // RULE8

  // Group activity that restarts each timer: input devices, and the general groups.
  wire logic [NUM_TIMERS-1:0] group_activity = {pin_rise[3] | gpio_event, pin_rise[2]}; // RULE18

  ////////////////////////////////////////////////////////////////////////////
  // Half-second prescaler shared by timers and the LED.

  logic [31:0] prescale_q;
  wire logic half_tick = prescale_q == HALF_SEC_CYCLES - 32'd1;

  // Free running so every time base steps on the same half-second grid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= 32'h00000000;
    end else begin
      prescale_q <= half_tick ? 32'h00000000 : prescale_q + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity timers.

  logic [11:0] unit_q [NUM_TIMERS];
  logic [4:0] count_q [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] timeout_q;
  logic [NUM_TIMERS-1:0] expire;

  genvar gt;
  generate
    for (gt = 0; gt < NUM_TIMERS; gt++) begin : g_timer
      // Length of one unit in half seconds, doubled when asked.
      logic [11:0] base_halves;
      always_comb begin
        unique case (time_base_e'(timer_cfg_q[gt].time_base_field)) // RULE1
          BASE_1S: base_halves = `HALVES_1S;
          BASE_10S: base_halves = `HALVES_10S;
          BASE_1MIN: base_halves = `HALVES_1MIN;
          BASE_10MIN: base_halves = `HALVES_10MIN;
        endcase
      end
      wire logic [11:0] unit_len = double_time_base ? {base_halves[10:0], 1'b0}
                                                    : base_halves; // RULE14
      wire logic [4:0] target = (timer_cfg_q[gt].timer_count_nibble == 4'h0)
                                ? `TIMEOUT_ZERO_UNITS
                                : {1'b0, timer_cfg_q[gt].timer_count_nibble}; // RULE4 RULE14
      wire logic unit_end = half_tick & (unit_q[gt] >= unit_len - 12'd1);
      assign expire[gt] = unit_end & (count_q[gt] + 5'd1 == target); // RULE18

      // Count up in units while running; stop bit or activity clears it.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unit_q[gt] <= 12'h000;
          count_q[gt] <= 5'h00;
          timeout_q[gt] <= 1'b0;
        end else begin
          timeout_q[gt] <= timer_cfg_q[gt].run & ~group_activity[gt] & expire[gt];
          if (!timer_cfg_q[gt].run || group_activity[gt]) begin // RULE2 RULE18
            unit_q[gt] <= 12'h000;
            count_q[gt] <= 5'h00;
          end else if (unit_end) begin
            unit_q[gt] <= 12'h000;
            count_q[gt] <= expire[gt] ? 5'h00 : count_q[gt] + 5'd1; // RULE2
          end else if (half_tick) begin
            unit_q[gt] <= unit_q[gt] + 12'd1;
          end
        end
      end
    end
  endgenerate

  // Read view of each timer register.
  function automatic logic [7:0] timer_view(input timer_cfg_s cfg, input logic [4:0] cnt,
                                            input logic global_live);
    logic [3:0] nib;
    nib = (cfg.read_live | global_live) ? cnt[3:0] : cfg.timer_count_nibble; // RULE3 RULE16
    return {nib, cfg.read_live, cfg.run, cfg.time_base_field};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode LED flasher.

  logic [4:0] led_halves_q;
  logic led_phase_q;
  logic [4:0] led_half_len;

  // Half period in half seconds for the chosen flash period.
  always_comb begin
    unique case (led_cfg_q.led_period_field) // RULE10
      2'h0: led_half_len = `LED_HALVES_1S;
      2'h1: led_half_len = `LED_HALVES_4S;
      2'h2: led_half_len = `LED_HALVES_8S;
      2'h3: led_half_len = `LED_HALVES_16S;
    endcase
  end

  // Equal on and off halves give the fixed 50% duty cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_halves_q <= 5'h00;
      led_phase_q <= 1'b0;
    end else if (!led_cfg_q.led_flash_en) begin // RULE9
      led_halves_q <= 5'h00;
      led_phase_q <= 1'b0;
    end else if (half_tick) begin
      if (led_halves_q >= led_half_len - 5'd1) begin
        led_halves_q <= 5'h00;
        led_phase_q <= ~led_phase_q; // RULE9
      end else begin
        led_halves_q <= led_halves_q + 5'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.

  // Software-visible settings update at the completing edge of a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_cfg_q[0] <= timer_cfg_s'(`RST_TIMER);
      timer_cfg_q[1] <= timer_cfg_s'(`RST_TIMER);
      led_cfg_q <= led_cfg_s'(`RST_LED_MONITOR);
      misc_q <= 3'(`RST_MISC_ONE);
      irq_mask_q <= `RST_IRQ;
    end else if (wr_done) begin
      if (hit_input) timer_cfg_q[0] <= timer_cfg_s'(wbyte);
      if (hit_memory) timer_cfg_q[1] <= timer_cfg_s'(wbyte); // RULE5
      if (hit_led) led_cfg_q <= led_cfg_s'(wbyte);
      if (hit_misc) misc_q <= wbyte[2:0]; // RULE12 RULE13 RULE19
      if (hit_mask) irq_mask_q <= wbyte[2:0];
    end
  end

  // Sticky events; a new event in the cycle of a clearing write wins.
  wire logic [2:0] irq_set = {resume_write, timeout_q[1], timeout_q[0]};
  wire logic [2:0] irq_clr = (wr_done & hit_status) ? wbyte[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= `RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus answer.

  // Read mux; the reserved misc bits read as zero.
  wire logic global_live = misc_q[`MISC_GLOBAL_LIVE]; // RULE12
  wire logic [7:0] rd_byte =
      hit_input ? timer_view(timer_cfg_q[0], count_q[0], global_live) :
      hit_memory ? timer_view(timer_cfg_q[1], count_q[1], global_live) :
      hit_led ? 8'(led_cfg_q) :
      hit_misc ? {5'h00, misc_q} : // RULE19
      hit_status ? {5'h00, irq_status_q} :
      hit_mask ? {5'h00, irq_mask_q} : 8'h00;

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~hit_any;
      prdata_q <= (access & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic input_timeout_q;
  logic memory_timeout_q;
  logic display_q;
  logic gpio_q;
  logic led_q;
  logic irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_timeout_q <= 1'b0;
      memory_timeout_q <= 1'b0;
      display_q <= 1'b0;
      gpio_q <= 1'b0;
      led_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      input_timeout_q <= timeout_q[0]; // RULE18
      memory_timeout_q <= timeout_q[1]; // RULE18
      display_q <= disp_event;
      gpio_q <= gpio_event;
      led_q <= led_cfg_q.led_flash_en ? led_phase_q : mode_led_steady;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign input_timeout = input_timeout_q;
  assign memory_timeout = memory_timeout_q;
  assign display_activity = display_q;
  assign general_io_port_group_activity = gpio_q;
  assign resume_indicator = misc_q[`MISC_RESUME]; // RULE13
  assign mode_led = led_q;
  assign irq = irq_q;

endmodule // pmu_activity_timers

// >>> tb/activity_chk.sv
// Port-level assertion checker for the activity timer block.
`timescale 1ns/1ps
module activity_chk (
  // Clock, reset and register bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Monitored strobes, events and indicators.
  input wire logic isa_iow_n,
  input wire logic isa_memw_n,
  input wire logic input_timeout,
  input wire logic memory_timeout,
  input wire logic display_activity,
  input wire logic general_io_port_group_activity,
  input wire logic resume_indicator,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] strobe_age_q, strobe_age_d, cause_age_q, cause_age_d;
  logic strobe_low, cause;
  ////////////////////////////////////////////////////////////
  // Cycles since an ISA strobe was low and since a timeout or register write, saturating.
  assign strobe_low = !isa_iow_n || !isa_memw_n;
  assign cause = input_timeout || memory_timeout || (pready && pwrite);
  assign strobe_age_d = strobe_low ? 4'h0 : strobe_age_q + {3'h0, strobe_age_q != 4'hf};
  assign cause_age_d = cause ? 4'h0 : cause_age_q + {3'h0, cause_age_q != 4'hf};
  // Age registers start saturated so nothing counts as recent after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_age_q <= 4'hf;
      cause_age_q <= 4'hf;
    end else begin
      strobe_age_q <= strobe_age_d;
      cause_age_q <= cause_age_d;
    end
  end
  // The access phase is answered in the next cycle by a one-cycle pready.
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_answer; s_access |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("access not answered in one cycle");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error response without pready or with data");
  property p_misc; pready && !pwrite && paddr == 12'h0f4 |-> prdata[7:3] == 5'h0 &&
    prdata[2] == resume_indicator; endproperty
  a_misc: assert property (p_misc) else $error("misc register readback wrong");
  property p_in_pulse; input_timeout |=> !input_timeout [*6]; endproperty
  a_in_pulse: assert property (p_in_pulse) else $error("input timeout pulse too long");
  property p_mem_pulse; memory_timeout |=> !memory_timeout [*6]; endproperty
  a_mem_pulse: assert property (p_mem_pulse) else $error("memory timeout pulse too long");
  property p_disp; display_activity |-> strobe_age_q <= 4'h8 ##1 !display_activity; endproperty
  a_disp: assert property (p_disp) else $error("display pulse without a strobe");
  property p_gpio; general_io_port_group_activity |-> strobe_age_q <= 4'h8
    ##1 !general_io_port_group_activity; endproperty
  a_gpio: assert property (p_gpio) else $error("io group pulse without a strobe");
  property p_irq; $rose(irq) |-> cause_age_q <= 4'h4; endproperty
  a_irq: assert property (p_irq) else $error("interrupt rose without a cause");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read data bits not zero");
endmodule // activity_chk

bind pmu_activity_timers activity_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .isa_iow_n, .isa_memw_n, .input_timeout,
  .memory_timeout, .display_activity, .general_io_port_group_activity, .resume_indicator,
  .irq);

// >>> tb/isa_side_model.sv
// Behavioural model of the monitored ISA bus and the activity pins.
`timescale 1ns/1ps
module isa_side_model (
  // Clock.
  input wire logic pclk,
  // Pins driven toward the block.
  output logic [23:0] isa_addr,
  output logic isa_iow_n,
  output logic isa_memw_n,
  output logic input_device_activity,
  output logic general_memory_region_group_hit
);
  // Idle bus at time zero.
  initial begin
    isa_addr = 24'h5a5a5a;
    isa_iow_n = 1'b1;
    isa_memw_n = 1'b1;
    input_device_activity = 1'b0;
    general_memory_region_group_hit = 1'b0;
  end
  // One write: address first, strobe low five cycles, then the released address inverts.
  task automatic write_cycle(input logic mem, input logic [23:0] a);
    @(posedge pclk);
    isa_addr <= a;
    @(posedge pclk);
    if (mem) isa_memw_n <= 1'b0;
    else isa_iow_n <= 1'b0;
    repeat (5) @(posedge pclk);
    isa_iow_n <= 1'b1;
    isa_memw_n <= 1'b1;
    @(posedge pclk);
    isa_addr <= ~a;
    repeat (4) @(posedge pclk);
  endtask
  // Raise one activity pin for five cycles.
  task automatic poke(input logic mem);
    @(posedge pclk);
    if (mem) general_memory_region_group_hit <= 1'b1;
    else input_device_activity <= 1'b1;
    repeat (5) @(posedge pclk);
    general_memory_region_group_hit <= 1'b0;
    input_device_activity <= 1'b0;
  endtask
endmodule // isa_side_model

// >>> tb/tb.sv
// Self-checking testbench of the activity timer block.
`timescale 1ns/1ps
`include "pmu_activity_timers_defs.svh"
module tb;
  localparam int HS = 4;
  localparam logic [11:0] A_IT = 12'(`BYTE_ADDR(`IDX_INPUT_TIMER));
  localparam logic [11:0] A_MT = 12'(`BYTE_ADDR(`IDX_MEMORY_TIMER));
  localparam logic [11:0] A_LED = 12'(`BYTE_ADDR(`IDX_LED_MONITOR));
  localparam logic [11:0] A_MISC = 12'(`BYTE_ADDR(`IDX_MISC_ONE));
  localparam logic [11:0] A_ST = 12'(`BYTE_ADDR(`IDX_IRQ_STATUS));
  localparam logic [11:0] A_MK = 12'(`BYTE_ADDR(`IDX_IRQ_MASK));
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] isa_addr;
  logic isa_iow_n, isa_memw_n, input_device_activity, general_memory_region_group_hit;
  logic double_time_base, mode_led_steady, input_timeout, memory_timeout, display_activity;
  logic general_io_port_group_activity, resume_indicator, mode_led, irq;
  logic [35:0] cs;
  logic [5:0] ev;
  int error_cnt, tests_run, c, k, j, kd, kg, lh [4] = '{1, 4, 8, 16};
  // Led, full decode, memory cycle, address, display and io group expectations.
  localparam logic [35:0] CASES [10] = '{{8'h03, 2'b10, 24'h0003b4, 2'b10},
    {8'h03, 2'b11, 24'h0a1234, 2'b10}, {8'h00, 2'b10, 24'h0003b4, 2'b00},
    {8'h00, 2'b11, 24'h0b0000, 2'b00}, {8'h04, 2'b10, 24'h000150, 2'b01},
    {8'h04, 2'b10, 24'h000250, 2'b00}, {8'h08, 2'b10, 24'h000250, 2'b01},
    {8'h10, 2'b10, 24'h0003f0, 2'b01}, {8'h04, 2'b10, 24'h001150, 2'b00},
    {8'h04, 2'b00, 24'h001150, 2'b01}};
  assign ev = {!mode_led, mode_led, general_io_port_group_activity, display_activity,
    memory_timeout, input_timeout};
  // Clock source.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  pmu_activity_timers #(.HALF_SEC_CYCLES(HS), .NUM_TIMERS(2)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .isa_addr, .isa_iow_n,
    .isa_memw_n, .input_device_activity, .general_memory_region_group_hit, .double_time_base,
    .mode_led_steady, .input_timeout, .memory_timeout, .display_activity,
    .general_io_port_group_activity, .resume_indicator, .mode_led, .irq);
  isa_side_model m (.pclk, .isa_addr, .isa_iow_n, .isa_memw_n, .input_device_activity,
    .general_memory_region_group_hit);
  ////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Setup cycle, then access held until pready is sampled high at a rising edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    do begin @(posedge pclk); c++; end while (pready !== 1'b1 && c < 20);
    if (c >= 20) begin error_cnt++; conclude(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 8'h0);
    chk(r, x);
  endtask
  // Bounded wait for an event; running out ends the run as a mismatch.
  task automatic wait_ev(input int i, input int lim);
    c = 0;
    do begin @(negedge pclk); c++; end while (ev[i] !== 1'b1 && c < lim);
    if (c >= lim) begin error_cnt++; conclude(); end
  endtask
  // Timer period between two expiries; stopped first so the count starts clean.
  task automatic t_period(input logic s, input logic [7:0] cfg, input logic d2, input int x);
    wr(s ? A_MT : A_IT, 8'h00);
    double_time_base <= d2;
    wr(s ? A_MT : A_IT, cfg);
    wait_ev(s, 20000);
    wait_ev(s, 20000);
    chk(32'(c), 32'(x));
    wr(s ? A_MT : A_IT, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  // Scenario sequence.
  initial begin
    error_cnt = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, double_time_base, mode_led_steady} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(A_IT, 32'h00);
    rdc(A_MT, 32'h00);
    rdc(A_LED, 32'h03);
    rdc(A_MISC, 32'h01);
    rdc(12'h100, 32'h0);
    chk(e, 1'b1);
    wr(A_MISC, 8'hfb);
    rdc(A_MISC, 32'h03);
    wr(A_MISC, 8'h01);
    $display("register defaults done");
    t_period(0, 8'h14, 0, 2 * HS);
    t_period(0, 8'h15, 0, 20 * HS);
    t_period(0, 8'h16, 0, 120 * HS);
    t_period(0, 8'h17, 0, 1200 * HS);
    t_period(0, 8'h04, 0, 32 * HS);
    t_period(1, 8'h34, 1, 12 * HS);
    double_time_base <= 1'b0;
    $display("timer periods done");
    wr(A_IT, 8'hf4);
    rdc(A_IT, 32'hf4);
    repeat (20) @(posedge pclk);
    wr(A_MISC, 8'h03);
    bus(1'b0, A_IT, 8'h0);
    chk(32'(r[7:4] inside {[4'h2:4'h4]}), 32'h1);
    wr(A_MISC, 8'h01);
    wr(A_IT, 8'h08);
    rdc(A_IT, 32'h08);
    wr(A_MISC, 8'h03);
    wr(A_IT, 8'hf0);
    rdc(A_IT, 32'h00);
    wr(A_MISC, 8'h01);
    $display("readback done");
    wr(A_ST, 8'h07);
    wr(A_IT, 8'h14);
    wait_ev(0, 100);
    wr(A_IT, 8'h00);
    rdc(A_ST, 32'h1);
    chk(irq, 1'b0);
    wr(A_MK, 8'h1);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b1);
    wr(A_ST, 8'h1);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    wr(A_MISC, 8'h05);
    @(negedge pclk);
    chk(resume_indicator, 1'b1);
    rdc(A_ST, 32'h4);
    wr(A_ST, 8'h4);
    wr(A_MISC, 8'h01);
    $display("interrupt done");
    for (int s = 0; s < 2; s++) begin
      wr(s ? A_MT : A_IT, 8'h24);
      k = 0;
      repeat (6) begin
        fork
          m.poke(s[0]);
          begin j = 0; repeat (10) begin @(negedge pclk); j += ev[s]; end end
        join
        k += j;
      end
      chk(32'(k), 32'h0);
      wait_ev(s, 40);
      wr(s ? A_MT : A_IT, 8'h00);
    end
    wr(A_MK, 8'h0);
    $display("activity clear done");
    for (int i = 0; i < 10; i++) begin
      cs = CASES[i];
      wr(A_LED, cs[35:28]);
      wr(A_MISC, {7'h0, cs[27]});
      kd = 0;
      kg = 0;
      fork
        m.write_cycle(cs[26], cs[25:2]);
        repeat (18) begin @(negedge pclk); kd += ev[2]; kg += ev[3]; end
      join
      chk(32'(kd), 32'(cs[1]));
      chk(32'(kg), 32'(cs[0]));
    end
    wr(A_MISC, 8'h01);
    $display("monitor ranges done");
    for (int i = 0; i < 4; i++) begin
      wr(A_LED, {i[1:0], 6'h23});
      wait_ev(5, 300);
      wait_ev(4, 300);
      wait_ev(5, 300);
      chk(32'(c), 32'(lh[i] * HS));
      wait_ev(4, 300);
      chk(32'(c), 32'(lh[i] * HS));
    end
    wr(A_LED, 8'h03);
    mode_led_steady <= 1'b1;
    repeat (4) @(negedge pclk);
    chk(mode_led, 1'b1);
    $display("led flash done");
    conclude();
  end
endmodule // tb
